// [dv/acrp_host_model.sv]
// host end of the serial link: makes shift clock and frame sync, reads frames
// assumes the data pin has no pull; the clock stands still outside calls
`timescale 1ns/1ns
module acrp_host_model
(
   output logic o_shift_clk,
   output logic o_frame_sync_n,
   input wire logic i_sdo,
   input wire logic i_sdo_oe,
   output logic [15:0] o_word,
   output logic o_word_valid
);
   logic last_q;
   logic pin;
   // a released pin shows the inverse of its last level, never a stale copy
   assign pin = i_sdo_oe ? i_sdo : ~last_q;
   initial
   begin
      o_shift_clk = 1'b0;
      o_frame_sync_n = 1'b1;
      o_word = 16'h0000;
      o_word_valid = 1'b0;
      last_q = 1'b0;
   end
   task automatic tick();
      #32 o_shift_clk = 1'b1;
      #32 o_shift_clk = 1'b0;
      last_q = pin;
   endtask
   task automatic read_frame();
      o_frame_sync_n = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         tick();
         o_word[15-i] = last_q;
      end
      o_frame_sync_n = 1'b1;
      tick();
      o_word_valid = 1'b1;
      #1 o_word_valid = 1'b0;
   endtask
endmodule

// [dv/acrp_top_properties.sv]
// concurrent checks on the readout port, bound into acrp_top
// assumes the shift clock only runs inside frames and a short idle burst before them
`timescale 1ns/1ns
module acrp_top_chk
#(
   parameter int unsigned CONV_CYCLES = 8
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_sample_trigger,
   input wire logic i_mode_parallel,
   input wire logic i_bipolar_range,
   input wire logic [acrp_pkg::RESULT_W-1:0] i_sar_code,
   input wire logic i_read_n,
   input wire logic i_chip_sel_n,
   input wire logic i_shift_clk,
   input wire logic i_frame_sync_in_n,
   input wire logic o_hold_sample,
   input wire logic o_done_n,
   input wire logic [acrp_pkg::RESULT_W-1:0] o_result_bits,
   input wire logic [acrp_pkg::RESULT_W-1:0] o_result_oe,
   input wire logic o_serial_result_out,
   input wire logic o_serial_oe
);
   import acrp_pkg::*;
   logic [15:0] cnt_q, cnt_d;
   logic [2:0] pend_q, pend_d;
   logic hold_q, done_q;
   // pending conversions: a done pulse needs a finished conversion behind it
   always_comb
   begin
      cnt_d = o_hold_sample ? cnt_q + 16'h0001 : 16'h0000;
      pend_d = pend_q + {2'h0, hold_q & ~o_hold_sample} - {2'h0, done_q & ~o_done_n};
   end
   always_ff @(posedge i_clk)
   begin
      cnt_q <= i_sys_rst ? 16'h0000 : cnt_d;
      pend_q <= i_sys_rst ? 3'h0 : pend_d;
      hold_q <= i_sys_rst ? 1'b0 : o_hold_sample;
      done_q <= i_sys_rst ? 1'b1 : o_done_n;
   end
   sequence s_done_tail;
      (!o_done_n)[*4] ##1 o_done_n;
   endsequence
   sequence s_frame_open;
      i_frame_sync_in_n ##1 (!i_frame_sync_in_n && !i_mode_parallel);
   endsequence
   a_done_width: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $fell(o_done_n) |=> s_done_tail) else $error("done pulse width wrong");
   a_done_cause: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $fell(o_done_n) |-> pend_q != 3'h0) else $error("done without conversion");
   a_hold_length: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $fell(o_hold_sample) |-> cnt_q == CONV_CYCLES[15:0]) else $error("hold length wrong");
   a_hold_cause: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_hold_sample) |-> $past(i_sample_trigger, 2)) else $error("hold without trigger");
   a_bus_enable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_result_oe != 12'h000 |-> !$past(i_read_n, 3) && !$past(i_chip_sel_n, 3)
      && $past(i_mode_parallel, 3))
      else $error("bus driven without read and select");
   a_bus_whole: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_result_oe != 12'hfff |-> o_result_oe == 12'h000 && o_result_bits == 12'h000)
      else $error("bus partly driven");
   a_bus_stable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_result_oe[0] && $past(o_result_oe[0]) |-> $stable(o_result_bits))
      else $error("result changed during read");
   a_serial_excl: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_serial_oe |-> o_result_oe == 12'h000) else $error("bus driven in serial mode");
   a_lead_zeros: assert property (@(posedge i_shift_clk) disable iff (i_sys_rst)
      s_frame_open |=> (!o_serial_result_out)[*4]) else $error("leading bits not zero");
endmodule

bind acrp_top acrp_top_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.i_clk(i_clk),
   .i_sys_rst(i_sys_rst), .i_sample_trigger(i_sample_trigger),
   .i_mode_parallel(i_mode_parallel), .i_bipolar_range(i_bipolar_range),
   .i_sar_code(i_sar_code), .i_read_n(i_read_n), .i_chip_sel_n(i_chip_sel_n),
   .i_shift_clk(i_shift_clk), .i_frame_sync_in_n(i_frame_sync_in_n),
   .o_hold_sample(o_hold_sample), .o_done_n(o_done_n), .o_result_bits(o_result_bits),
   .o_result_oe(o_result_oe), .o_serial_result_out(o_serial_result_out),
   .o_serial_oe(o_serial_oe));

// [dv/tb_adc_conversion_readout_port.sv]
// self-checking bench for acrp_top: parallel reads and serial frames
// assumes acrp_host_model on the serial link and the bound checker
`timescale 1ns/1ns
module tb_adc_conversion_readout_port;
   import acrp_pkg::*;
   logic clk, rst, trig, mode, bip, rd_n, cs_n, oe_prev, hold, done_n, sdo, sdo_oe;
   logic sclk, fs_n, w_valid;
   logic [RESULT_W-1:0] code, bits, oe, res_last;
   logic [RESULT_W-1:0] tbl [4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
   logic [15:0] word;
   logic [31:0] rng;
   logic [15:0] exp_q [$];
   int fails, checks_done;
   acrp_top #(.CONV_CYCLES(8)) dut (.i_clk(clk), .i_sys_rst(rst), .i_sample_trigger(trig),
      .i_mode_parallel(mode), .i_bipolar_range(bip), .i_sar_code(code), .i_read_n(rd_n),
      .i_chip_sel_n(cs_n), .i_shift_clk(sclk), .i_frame_sync_in_n(fs_n),
      .o_hold_sample(hold), .o_done_n(done_n), .o_result_bits(bits), .o_result_oe(oe),
      .o_serial_result_out(sdo), .o_serial_oe(sdo_oe));
   acrp_host_model host (.o_shift_clk(sclk), .o_frame_sync_n(fs_n), .i_sdo(sdo),
      .i_sdo_oe(sdo_oe), .o_word(word), .o_word_valid(w_valid));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", name, e, g);
         fails++;
      end
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp_next(input logic [15:0] g);
      if (exp_q.size() == 0)
         chk("unexpected result", 16'hffff, g);
      else
         chk("result", exp_q.pop_front(), g);
   endtask
   // outputs only move on rising edges, so the falling edge sees them settled
   always @(negedge clk)
   begin
      if (oe[0] === 1'b1 && oe_prev !== 1'b1)
         cmp_next({4'h0, bits});
      oe_prev = oe[0];
   end
   always @(posedge w_valid)
      cmp_next(word);
   task automatic start(input logic [11:0] c);
      @(negedge clk);
      code = c;
      trig = 1'b1;
      repeat (6) @(negedge clk);
      trig = 1'b0;
   endtask
   task automatic finish_conv(input logic [11:0] c);
      int n;
      n = 0;
      while (done_n !== 1'b0 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      chk("done_n", 16'h0000, {15'h0, done_n});
      if (n >= 400)
         tally_and_finish();
      res_last = c ^ (bip ? 12'h800 : 12'h000);
      repeat (8) @(negedge clk);
   endtask
   task automatic par_read();
      @(negedge clk);
      rd_n = 1'b0;
      cs_n = 1'b0;
      repeat (6) @(negedge clk);
      rd_n = 1'b1;
      cs_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask
   initial
   begin
      rst = 1'b1;
      trig = 1'b0;
      mode = 1'b1;
      bip = 1'b0;
      rd_n = 1'b1;
      cs_n = 1'b1;
      code = 12'h000;
      res_last = 12'h000;
      oe_prev = 1'b0;
      rng = 32'd73752;
      fails = 0;
      checks_done = 0;
      // link reset needs shift clock edges as well as system edges
      fork
         repeat (4) @(negedge clk);
         repeat (4) host.tick();
      join
      @(negedge clk);
      rst = 1'b0;
      chk("done_n reset", 16'h0001, {15'h0, done_n});
      chk("oe reset", 16'h0000, {4'h0, oe});
      for (int i = 0; i < 8; i++)
      begin
         rng = xs(rng);
         bip = i[0];
         start(i < 4 ? tbl[i] : rng[11:0]);
         finish_conv(i < 4 ? tbl[i] : rng[11:0]);
         exp_q.push_back({4'h0, res_last});
         par_read();
      end
      for (int k = 0; k < 2; k++)
      begin
         {rd_n, cs_n} = k ? 2'b01 : 2'b10;
         repeat (6) @(negedge clk);
         chk("oe half enable", 16'h0000, {4'h0, oe});
         {rd_n, cs_n} = 2'b11;
         repeat (4) @(negedge clk);
      end
      // a conversion finishing mid-read must wait until the read ends
      exp_q.push_back({4'h0, res_last});
      rd_n = 1'b0;
      cs_n = 1'b0;
      start(12'h5a3);
      repeat (30) @(negedge clk);
      chk("held result", {4'h0, res_last}, {4'h0, bits});
      rd_n = 1'b1;
      cs_n = 1'b1;
      finish_conv(12'h5a3);
      exp_q.push_back({4'h0, res_last});
      par_read();
      mode = 1'b0;
      repeat (3) host.tick();
      chk("serial oe", 16'h0001, {15'h0, sdo_oe});
      for (int j = 0; j < 2; j++)
      begin
         rng = xs(rng);
         bip = j[0];
         start(rng[11:0]);
         finish_conv(rng[11:0]);
         exp_q.push_back({4'h0, res_last});
         host.read_frame();
         repeat (4) @(negedge clk);
      end
      chk("oe serial", 16'h0000, {4'h0, oe});
      chk("queue left", 16'h0000, 16'(exp_q.size()));
      tally_and_finish();
   end
endmodule

// [include/acrp_buf_if.sv]
// valid/ready carrier between the conversion logic and the result buffer
// assumes one clock domain on both sides
`timescale 1ns/1ns
interface acrp_buf_if
#(
   parameter int unsigned WIDTH = 12
);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;

   modport src
   (
      output valid,
      output data,
      input ready
   );

   modport snk
   (
      input valid,
      input data,
      output ready
   );
endinterface

// [include/acrp_pkg.sv]
// constants and types for the converter result readout port
// assumes a 50 MHz system clock; the serial shift clock comes from the host
package acrp_pkg;
   localparam int unsigned RESULT_W = 12;
   localparam int unsigned FRAME_W = 16;
   localparam int unsigned LEAD_ZEROS = 4;
   localparam int unsigned BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] FRAME_BITS = 5'h10;
   localparam logic [RESULT_W-1:0] BIPOLAR_FLIP = 12'h800;
   localparam logic [LEAD_ZEROS-1:0] LEAD_PATTERN = 4'h0;
   // shared pin positions on the parallel bus
   localparam int unsigned PIN_FSYNC_BIT = 3;
   localparam int unsigned PIN_SCLK_BIT = 4;
   localparam int unsigned PIN_SERIAL_OUT_BIT = 5;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned DONE_PULSE_NS = 100;
   localparam int unsigned DONE_CYCLES_RAW = DONE_PULSE_NS / CLK_PERIOD_NS;
   localparam int unsigned DONE_CYCLES = (DONE_CYCLES_RAW < 1) ? 1 : DONE_CYCLES_RAW;
   localparam int unsigned DONE_CNT_W = 4;
   localparam logic [DONE_CNT_W-1:0] DONE_CNT_LOAD = DONE_CYCLES[DONE_CNT_W-1:0];
   localparam int unsigned CONV_CYCLES_DEF = 80;
   localparam int unsigned CONV_CNT_W = 16;
   localparam int unsigned BUF_DEPTH = 2;
   // synchroniser bit order: trigger, mode, bipolar, read_n, chip_sel_n, frame busy
   localparam int unsigned SYNC_W = 6;
   localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 6'h18;
   localparam int unsigned SY_TRIG = 0;
   localparam int unsigned SY_MODE = 1;
   localparam int unsigned SY_BIP = 2;
   localparam int unsigned SY_RD_N = 3;
   localparam int unsigned SY_CS_N = 4;
   localparam int unsigned SY_BUSY = 5;

   typedef enum logic [1:0] {
      ACRP_IDLE,
      ACRP_CONVERT,
      ACRP_DELIVER
   } acrp_state_t;
endpackage

// [rtl/acrp_buf.sv]
// small result buffer with valid/ready on both sides
// assumes synchronous active-high reset on the same clock as both ports
`timescale 1ns/1ns
module acrp_buf
#(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 2
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   acrp_buf_if.snk fill,
   acrp_buf_if.src drain
);
   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = DEPTH[CNT_W-1:0];
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic push, pop;

   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      bump = (p == LAST_PTR) ? '0 : p + 1'b1;
   endfunction

   always_comb
   begin
      fill.ready = (cnt_q != FULL_CNT);
      drain.valid = (cnt_q != '0);
      drain.data = mem_q[rd_q];
      push = fill.valid && fill.ready;
      pop = drain.valid && drain.ready;
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push)
      begin
         mem_d[wr_q] = fill.data;
         wr_d = bump(wr_q);
      end
      if (pop)
      begin
         rd_d = bump(rd_q);
      end
      if (push && !pop)
      begin
         cnt_d = cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_q[i] <= '0;
         end
      end
      else
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         mem_q <= mem_d;
      end
   end
endmodule

// [rtl/acrp_top.sv]
// digital control and result readout of a 12-bit sampling converter
// assumes i_sar_code is settled by the end of the conversion count and that the
// host supplies the shift clock and frame sync for serial readout
// Functional notes
// (R1) parallel mode: shared pin is result bit 4; serial mode: shift clock input
// (R2) host must supply the shift clock; the device never makes one
// (R3) after frame sync falls, result bits shift out on rising shift clock edges
// (R4) host drives frame sync low to open a frame; parallel mode: bit 3
// (R5) parallel mode lowest line is bit 0; low lines unused in serial mode
// (R6) bipolar ranges give two's complement, unipolar gives straight binary
// (R7) parallel outputs driven only while read and chip select are both low
// (R8) host must assert chip select together with read to see the bus
// (R9) end of conversion gives a 100 ns active-low done pulse, else high
// (R10) rising sample trigger edge holds the input and starts a conversion
// (R11) static mode input: high selects parallel bus, low selects serial link
// (R12) serial frame is sixteen bits: four leading zeros then 12 result bits
// (R13) host samples serial data on sixteen falling edges after frame sync
// (R14) parallel mode highest line is bit 11, the most significant bit
// (R15) latest result stays in the output register until the next one replaces it
`timescale 1ns/1ns
module acrp_top
#(
   parameter int unsigned CONV_CYCLES = acrp_pkg::CONV_CYCLES_DEF
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_sample_trigger,
   input wire logic i_mode_parallel,
   input wire logic i_bipolar_range,
   input wire logic [acrp_pkg::RESULT_W-1:0] i_sar_code,
   input wire logic i_read_n,
   input wire logic i_chip_sel_n,
   input wire logic i_shift_clk,
   input wire logic i_frame_sync_in_n,
   output logic o_hold_sample,
   output logic o_done_n,
   output logic [acrp_pkg::RESULT_W-1:0] o_result_bits,
   output logic [acrp_pkg::RESULT_W-1:0] o_result_oe,
   output logic o_serial_result_out,
   output logic o_serial_oe
);
   import acrp_pkg::*;

   localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);

   // system domain state
   logic [SYNC_W-1:0] sync1_q, sync2_q;
   logic trig_prev_q;
   acrp_state_t st_q, st_d;
   logic [CONV_CNT_W-1:0] conv_cnt_q, conv_cnt_d;
   logic [RESULT_W-1:0] code_q, code_d;
   logic [RESULT_W-1:0] result_q, result_d;
   logic [DONE_CNT_W-1:0] done_cnt_q, done_cnt_d;
   logic done_n_q, done_n_d;
   logic hold_q, hold_d;
   logic [RESULT_W-1:0] bus_q, bus_d;
   logic [RESULT_W-1:0] bus_oe_q, bus_oe_d;
   logic trig_rise, read_active, bus_enable;
   logic fsync1_n_q, fsync2_n_q, frame_open;

   // link domain state
   logic lrst1_q, lrst2_q;
   logic lmode1_q, lmode2_q;
   logic [FRAME_W-1:0] shift_q, shift_d;
   logic [BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
   logic sdo_q, sdo_d;
   logic soe_q, soe_d;
   logic busy_q, busy_d;

   acrp_buf_if #(.WIDTH(RESULT_W)) fill_if ();
   acrp_buf_if #(.WIDTH(RESULT_W)) drain_if ();

   // offset-binary core code to the output coding of the selected range
   function automatic logic [RESULT_W-1:0] coded(input logic [RESULT_W-1:0] raw,
                                                 input logic bipolar);
      coded = bipolar ? (raw ^ BIPOLAR_FLIP) : raw;
   endfunction

   acrp_buf #(
      .WIDTH(RESULT_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .fill(fill_if.snk),
      .drain(drain_if.src)
   );

   // pins and the link busy flag cross into the system clock
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         sync1_q <= SYNC_RST_VAL;
         sync2_q <= SYNC_RST_VAL;
         trig_prev_q <= 1'b0;
      end
      else
      begin
         sync1_q <= {busy_q, i_chip_sel_n, i_read_n, i_bipolar_range, i_mode_parallel,
                     i_sample_trigger};
         sync2_q <= sync1_q;
         trig_prev_q <= sync2_q[SY_TRIG];
      end
   end

   // frame sync also crosses here: it falls ahead of the first shift edge, so the
   // output register freezes earlier than the link busy flag alone would allow
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         fsync1_n_q <= 1'b1;
         fsync2_n_q <= 1'b1;
      end
      else
      begin
         fsync1_n_q <= i_frame_sync_in_n;
         fsync2_n_q <= fsync1_n_q;
      end
   end

   always_comb
   begin
      trig_rise = sync2_q[SY_TRIG] && !trig_prev_q; // R10
      read_active = !sync2_q[SY_RD_N] && !sync2_q[SY_CS_N]; // R8
      bus_enable = sync2_q[SY_MODE] && read_active; // R7 R11
      frame_open = !sync2_q[SY_MODE] && !fsync2_n_q; // R4
   end

   // conversion sequencer; a trigger during a conversion is ignored
   always_comb
   begin
      st_d = st_q;
      conv_cnt_d = conv_cnt_q;
      code_d = code_q;
      hold_d = hold_q;
      fill_if.valid = (st_q == ACRP_DELIVER);
      fill_if.data = code_q;
      case (st_q)
         ACRP_IDLE:
         begin
            if (trig_rise)
            begin
               st_d = ACRP_CONVERT; // R10
               conv_cnt_d = '0;
               hold_d = 1'b1;
            end
         end
         ACRP_CONVERT:
         begin
            if (conv_cnt_q == CONV_LAST)
            begin
               st_d = ACRP_DELIVER;
               code_d = coded(i_sar_code, sync2_q[SY_BIP]); // R6
               hold_d = 1'b0;
            end
            else
            begin
               conv_cnt_d = conv_cnt_q + 1'b1;
            end
         end
         ACRP_DELIVER:
         begin
            // a full buffer stalls here, and a trigger edge arriving meanwhile is ignored
            if (fill_if.ready)
            begin
               st_d = ACRP_IDLE;
            end
         end
         default:
         begin
            st_d = ACRP_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         st_q <= ACRP_IDLE;
         conv_cnt_q <= '0;
         code_q <= '0;
         hold_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         conv_cnt_q <= conv_cnt_d;
         code_q <= code_d;
         hold_q <= hold_d;
      end
   end

   // output register: never changes under a bus read or an open serial frame
   always_comb
   begin
      drain_if.ready = !read_active && !sync2_q[SY_BUSY] && !frame_open;
      result_d = result_q;
      done_cnt_d = (done_cnt_q != '0) ? done_cnt_q - 1'b1 : done_cnt_q;
      if (drain_if.valid && drain_if.ready)
      begin
         result_d = drain_if.data; // R15
         done_cnt_d = DONE_CNT_LOAD; // R9
      end
      done_n_d = (done_cnt_d == '0); // R9
      bus_d = bus_enable ? result_q : '0; // R5 R14
      bus_oe_d = {RESULT_W{bus_enable}}; // R7 R1 R4
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         result_q <= '0;
         done_cnt_q <= '0;
         done_n_q <= 1'b1;
         bus_q <= '0;
         bus_oe_q <= '0;
      end
      else
      begin
         result_q <= result_d;
         done_cnt_q <= done_cnt_d;
         done_n_q <= done_n_d;
         bus_q <= bus_d;
         bus_oe_q <= bus_oe_d;
      end
   end

   always_comb
   begin
      o_hold_sample = hold_q;
      o_done_n = done_n_q;
      o_result_bits = bus_q;
      o_result_oe = bus_oe_q;
      o_serial_result_out = sdo_q;
      o_serial_oe = soe_q;
   end

   // link domain, clocked by the host's shift clock
   // the clock may stop between frames, so reset and mode only settle once it runs
   always_ff @(posedge i_shift_clk)
   begin
      lrst1_q <= i_sys_rst;
      lrst2_q <= lrst1_q;
      lmode1_q <= i_mode_parallel;
      lmode2_q <= lmode1_q;
   end

   // result_q is held still while busy is seen in the system domain
   // a frame cut short by frame sync only restarts its count once frame sync
   // is seen high at a shift edge, so the host must leave one edge between frames
   always_comb
   begin
      shift_d = shift_q;
      bit_cnt_d = bit_cnt_q;
      sdo_d = 1'b0;
      busy_d = busy_q;
      soe_d = !lmode2_q; // R11
      if (i_frame_sync_in_n || lmode2_q)
      begin
         bit_cnt_d = '0;
         busy_d = 1'b0;
      end
      else if (bit_cnt_q == '0)
      begin
         shift_d = {LEAD_PATTERN, result_q} << 1; // R12 R15
         sdo_d = LEAD_PATTERN[LEAD_ZEROS-1]; // R3 R12
         bit_cnt_d = bit_cnt_q + 1'b1;
         busy_d = 1'b1; // R4
      end
      else if (bit_cnt_q != FRAME_BITS)
      begin
         sdo_d = shift_q[FRAME_W-1]; // R3 R13
         shift_d = shift_q << 1;
         bit_cnt_d = bit_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge i_shift_clk)
   begin
      if (lrst2_q)
      begin
         shift_q <= '0;
         bit_cnt_q <= '0;
         sdo_q <= 1'b0;
         soe_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         shift_q <= shift_d; // R2
         bit_cnt_q <= bit_cnt_d;
         sdo_q <= sdo_d;
         soe_q <= soe_d;
         busy_q <= busy_d;
      end
   end
endmodule
